// ==== common/sweep_cmd_regs.vh ====
// register map, reply codes, messages and limits
// included by the interpreter and the testbench; holds definitions only
`ifndef SWEEP_CMD_REGS_VH
`define SWEEP_CMD_REGS_VH
// register word offsets (bus address bits 7:2)
`define OFS_CMD        6'h00
`define OFS_START      6'h01
`define OFS_STOP       6'h02
`define OFS_STEP       6'h03
`define OFS_DET_LO     6'h04
`define OFS_DET_HI     6'h05
`define OFS_HOLD       6'h06
`define OFS_RBW        6'h07
`define OFS_MIN_ATT    6'h08
`define OFS_PREAMP     6'h09
`define OFS_PRESEL     6'h0A
`define OFS_SCAN_HOLD  6'h0B
`define OFS_STATUS     6'h0C
`define OFS_SELECT     6'h0D
`define OFS_POINT      6'h0E
// command codes written to the command register
`define CMD_DET_SEL    2'h1
`define CMD_FREE_SWEEP 2'h2
`define CMD_ABORT      2'h3
// reply codes shown in the status register
`define RPL_NONE       5'h00
`define RPL_OK         5'h01
`define RPL_REJECT     5'h02
`define RPL_ACCEPT     5'h03
`define RPL_DONE       5'h04
`define RPL_ABORTED    5'h05
`define RPL_ERR_BASE   5'h10
// status field positions
`define ST_BUSY        5
`define ST_SMART       6
`define ST_MASK_LSB    7
`define ST_FFT         13
// limits, in their own units
`define HOLD_MAX_MS    32'h2710
`define FFT_HOLD_MS    32'h32
`define FFT_STOP_HZ    32'h249F0
`define FFT_SPAN_HZ    32'h1388
`define FFT_STEP_HZ    32'h32
`define FFT_RBW        32'h7
`define ATT_STEP_DB    8'h05
`define UNMEASURED     16'h8044
`define STR_ON         32'h4E4F
`define STR_OFF        32'h46464F
`define CASE_MASK      32'hDFDFDFDF
// text images, first character in the top byte
`define MSG_ACCEPT     96'h5346443D4F4B0D0A00000000
`define MSG_ERR_HEAD   64'h5346443D45525220
`define MSG_DONE       96'h53464420454E440D0A000000
`define MSG_ABORT      96'h53424B3D4F4B0D0A00000000
`define LEN_ACCEPT     4'h8
`define LEN_ERR        4'hB
`define LEN_DONE       4'h9
`define LEN_ABORT      4'h8
`endif

// ==== design/det_string_decode.v ====
// detector string decoder: letters to a fixed-order detector mask
// assumes up to eight characters, first in the low byte, ended by a zero byte
`timescale 1ns/100ps
`default_nettype none
module det_string_decode (
  // packed detector string
  input  wire [63:0] det_str,
  // decoded result
  output reg  [5:0]  det_mask,
  output reg         smart,
  output reg  [3:0]  n_letters,
  output reg         bad
);
  integer   i;
  reg       ended;
  reg [7:0] ch;
  reg [5:0] alt;

  // walk the characters, mask bit order peak,qpeak,rms,avg,c-rms,c-avg
  always @* begin
    det_mask  = 6'h00;
    smart     = 1'b0;
    n_letters = 4'h0;
    bad       = 1'b0;
    ended     = 1'b0;
    ch        = 8'h00;
    alt       = 6'h00;
    for (i = 0; i < 8; i = i + 1) begin
      ch = det_str[i*8 +: 8];
      if (ch == 8'h00) begin
        ended = 1'b1;
      end else if (!ended) begin
        if (ch != 8'h53) n_letters = n_letters + 4'h1;
        case (ch)
          8'h53:   if (i == 0) smart = 1'b1; else bad = 1'b1;
          8'h50:   det_mask[0] = 1'b1;
          8'h51:   det_mask[1] = 1'b1;
          8'h52:   det_mask[2] = 1'b1;
          8'h41:   det_mask[3] = 1'b1;
          8'h4E:   det_mask[4] = 1'b1;
          8'h43:   det_mask[5] = 1'b1;
          default: bad = 1'b1;
        endcase
      end
    end
    alt = det_mask & 6'h3E;
    if (n_letters == 4'h0) bad = 1'b1;
    // smart: exactly one alternative, peak added on top
    if (smart) begin
      if (det_mask[0] || alt == 6'h00 || (alt & (alt - 6'h01)) != 6'h00) bad = 1'b1;
      det_mask = alt | 6'h01;
    end
  end
endmodule // det_string_decode
`default_nettype wire

// ==== design/sweep_command_interpreter.v ====
// sweep command interpreter: detector select, free sweep check, result stream
// assumes an AXI4-Lite master on clk_sys and measurement logic on the same clock
// Function
// - detector select letter, optional smart, OK/reject
// - step sign picks stepwise, auto or table
// - non-smart accepts any detector letter combination
// - smart: S first, one alternative, peak
// - smart uses hold only for re-measure
// - bandwidth index applied as given
// - minimum attenuation multiple of five, else error6
// - preamp/preselector ON or OFF, errors 7/8
// - scan hold for smart peak, else minimum
// - reply accept and start, or error only
// - error1 on bad start/stop frequencies
// - error2 on small step or short table
// - error3 on detector string faults
// - error4 on negative or over-ten-second hold
// - error5 on unsuitable bandwidth index
// - two little-endian bytes per detector per step
// - fixed order peak,qp,rms,avg,crms,cavg
// - unmeasured detector sends the marker value
// - FFT only under the listed conditions
// - done message after last step data
// - abort stops at once, abort message
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`include "sweep_cmd_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module sweep_command_interpreter #(
  parameter [31:0] FREQ_MIN_HZ    = 32'h00000001,
  parameter [31:0] FREQ_MAX_HZ    = 32'h05F5E100,
  parameter [31:0] STEP_MIN_HZ    = 32'h00000001,
  parameter [31:0] AUTO_STEP_HZ   = 32'h000003E8,
  parameter [31:0] HOLD_WIDE_MS   = 32'h00000001,
  parameter [31:0] HOLD_NARROW_MS = 32'h0000000A
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // register bus
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // instrument context
  input  wire        limit_active,
  input  wire        unit_downconv,
  input  wire        mil_avail,
  input  wire [7:0]  max_att,
  input  wire [6:0]  scan_table_count,
  // measurement request and result
  output wire        meas_req,
  output wire [2:0]  meas_det,
  output wire [31:0] meas_hold_ms,
  output wire [31:0] tune_freq,
  output wire        tune_from_table,
  input  wire        meas_valid,
  input  wire        meas_unmeasured,
  input  wire [15:0] meas_value,
  // applied sweep settings
  output wire [4:0]  rbw_idx,
  output wire [7:0]  min_att,
  output wire        att_auto,
  output wire        preamp_on,
  output wire        presel_on,
  output wire        use_fft,
  // reply and data byte stream
  output wire        tx_valid,
  output wire [7:0]  tx_data,
  input  wire        tx_ready
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_MSG  = 3'h1;
  localparam [2:0] S_FIND = 3'h2;
  localparam [2:0] S_REQ  = 3'h3;
  localparam [2:0] S_TXLO = 3'h4;
  localparam [2:0] S_TXHI = 3'h5;

  // case-insensitive ON/OFF check
  function onoff_bad(input [31:0] s);
    reg [31:0] u;
    begin
      u         = s & `CASE_MASK;
      onoff_bad = (u != `STR_ON) && (u != `STR_OFF);
    end
  endfunction

  // bandwidth index suitable for unit and detector
  function rbw_fits(input [31:0] r, input dc, input mil, input qp);
    reg ok;
    begin
      if (dc) ok = (r >= 32'h1 && r <= 32'h5) || r == 32'h9 || r == 32'hA || r == 32'hC;
      else    ok = (r >= 32'h1 && r <= 32'h7) || (mil && (r == 32'hB || (r >= 32'h16 && r <= 32'h18)));
      if (qp && !(r == 32'h6 || r == 32'h7 || r == 32'hA)) ok = 1'b0;
      rbw_fits = ok;
    end
  endfunction

  // bus handshake state
  reg        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg        aw_ok_ff, w_ok_ff;
  reg [5:0]  waddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  reg [1:0]  bresp_ff, rresp_ff;
  reg [31:0] rdata_ff;
  // field registers
  reg [31:0] start_ff, stop_ff, step_ff, det_lo_ff, det_hi_ff, hold_ff;
  reg [31:0] rbw_ff, att_ff, preamp_ff, presel_ff, scan_hold_ff;
  // sweep engine
  reg [2:0]  state_ff;
  reg [95:0] msg_ff;
  reg [3:0]  msg_len_ff;
  reg        sweeping_ff, abort_ff;
  reg [4:0]  reply_ff;
  reg [5:0]  sel_mask_ff, sw_mask_ff;
  reg        sel_smart_ff, sw_smart_ff;
  reg [2:0]  det_idx_ff;
  reg [32:0] cur_ff, limit_ff;
  reg [31:0] step_amt_ff, point_ff;
  reg [15:0] val_ff;
  reg        meas_req_ff, table_ff, tx_valid_ff;
  reg [7:0]  tx_data_ff;
  reg [31:0] meas_hold_ff;
  reg [4:0]  rbw_out_ff;
  reg [7:0]  att_out_ff;
  reg        att_auto_ff, preamp_on_ff, presel_on_ff, fft_ff;

  wire [5:0] dec_mask;
  wire       dec_smart;
  wire [3:0] dec_letters;
  wire       dec_bad;

  det_string_decode u_dec (
    .det_str   ({det_hi_ff, det_lo_ff}),
    .det_mask  (dec_mask),
    .smart     (dec_smart),
    .n_letters (dec_letters),
    .bad       (dec_bad)
  );

  // write path: aw and w in either order
  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs  = s_axi_wvalid & wready_ff;
  wire do_wr = aw_ok_ff & w_ok_ff & ~bvalid_ff;
  wire ar_hs = s_axi_arvalid & arready_ff;
  wire map_w = (waddr_ff <= `OFS_SCAN_HOLD);
  wire cmd_wr = do_wr & (waddr_ff == `OFS_CMD) & wstrb_ff[0];
  wire [1:0] cmd = wdata_ff[1:0];

  // write with byte strobes
  function [31:0] wmerge(input [31:0] old);
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) wmerge[k*8 +: 8] = wstrb_ff[k] ? wdata_ff[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_ok_ff   <= 1'b0;
      w_ok_ff    <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      waddr_ff   <= 6'h00;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_ok_ff <= 1'b1;
        waddr_ff <= s_axi_awaddr[7:2];
      end else if (do_wr) begin
        aw_ok_ff <= 1'b0;
      end
      if (w_hs) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_wr) begin
        w_ok_ff <= 1'b0;
      end
      awready_ff <= ~(aw_ok_ff | aw_hs) & ~bvalid_ff & ~do_wr;
      wready_ff  <= ~(w_ok_ff | w_hs) & ~bvalid_ff & ~do_wr;
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= map_w ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // fields, frozen while sweeping
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_ff     <= 32'h0;
      stop_ff      <= 32'h0;
      step_ff      <= 32'h0;
      det_lo_ff    <= 32'h0;
      det_hi_ff    <= 32'h0;
      hold_ff      <= 32'h0;
      rbw_ff       <= 32'h0;
      att_ff       <= 32'h0;
      preamp_ff    <= 32'h0;
      presel_ff    <= 32'h0;
      scan_hold_ff <= 32'hFFFFFFFF;
    end else if (do_wr && !sweeping_ff) begin
      case (waddr_ff)
        `OFS_START:     start_ff     <= wmerge(start_ff);
        `OFS_STOP:      stop_ff      <= wmerge(stop_ff);
        `OFS_STEP:      step_ff      <= wmerge(step_ff);
        `OFS_DET_LO:    det_lo_ff    <= wmerge(det_lo_ff);
        `OFS_DET_HI:    det_hi_ff    <= wmerge(det_hi_ff);
        `OFS_HOLD:      hold_ff      <= wmerge(hold_ff);
        `OFS_RBW:       rbw_ff       <= wmerge(rbw_ff);
        `OFS_MIN_ATT:   att_ff       <= wmerge(att_ff);
        `OFS_PREAMP:    preamp_ff    <= wmerge(preamp_ff);
        `OFS_PRESEL:    presel_ff    <= wmerge(presel_ff);
        `OFS_SCAN_HOLD: scan_hold_ff <= wmerge(scan_hold_ff);
        default:        start_ff     <= start_ff;
      endcase
    end
  end

  // read path
  reg [31:0] rd_mux;
  reg        rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr[7:2])
      `OFS_CMD:       rd_mux = 32'h0;
      `OFS_START:     rd_mux = start_ff;
      `OFS_STOP:      rd_mux = stop_ff;
      `OFS_STEP:      rd_mux = step_ff;
      `OFS_DET_LO:    rd_mux = det_lo_ff;
      `OFS_DET_HI:    rd_mux = det_hi_ff;
      `OFS_HOLD:      rd_mux = hold_ff;
      `OFS_RBW:       rd_mux = rbw_ff;
      `OFS_MIN_ATT:   rd_mux = att_ff;
      `OFS_PREAMP:    rd_mux = preamp_ff;
      `OFS_PRESEL:    rd_mux = presel_ff;
      `OFS_SCAN_HOLD: rd_mux = scan_hold_ff;
      `OFS_STATUS:    rd_mux = {18'h0, fft_ff, sw_mask_ff, sw_smart_ff, sweeping_ff, reply_ff};
      `OFS_SELECT:    rd_mux = {25'h0, sel_smart_ff, sel_mask_ff};
      `OFS_POINT:     rd_mux = point_ff;
      default: begin
        rd_mux = 32'h0;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= 2'h0;
    end else begin
      arready_ff <= ~(ar_hs | (rvalid_ff & ~s_axi_rready));
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // field checks, first failing error number wins
  wire signed [31:0] step_s = step_ff;
  wire e1 = (start_ff < FREQ_MIN_HZ) || (stop_ff > FREQ_MAX_HZ) || (start_ff > stop_ff);
  wire e2 = (step_s > 0 && step_ff < STEP_MIN_HZ) || (step_s == 0 && scan_table_count < 7'h02);
  wire e3 = dec_bad || (dec_smart && !limit_active);
  wire e4 = hold_ff[31] || (hold_ff > `HOLD_MAX_MS);
  wire e5 = !rbw_fits(rbw_ff, unit_downconv, mil_avail, dec_mask[1]);
  wire e6 = att_ff[31] || (att_ff > {24'h000000, max_att}) || (att_ff[7:0] % `ATT_STEP_DB != 8'h00);
  wire e7 = onoff_bad(preamp_ff);
  wire e8 = onoff_bad(presel_ff);
  wire [3:0] errn = e1 ? 4'h1 : e2 ? 4'h2 : e3 ? 4'h3 : e4 ? 4'h4 :
                    e5 ? 4'h5 : e6 ? 4'h6 : e7 ? 4'h7 : e8 ? 4'h8 : 4'h0;
  wire [31:0] span = stop_ff - start_ff;
  wire fft_ok = ((dec_mask == 6'h01 && !dec_smart && hold_ff < `FFT_HOLD_MS) || dec_smart) &&
                stop_ff <= `FFT_STOP_HZ && span >= `FFT_SPAN_HZ &&
                step_ff == `FFT_STEP_HZ && rbw_ff == `FFT_RBW;
  wire det_sel_ok = !dec_bad && dec_letters == 4'h1 && !dec_mask[5];
  wire last_det  = (det_idx_ff == 3'h5);
  wire narrow    = (rbw_ff == 32'h7) || (rbw_ff >= 32'h16);
  wire [31:0] min_hold = narrow ? HOLD_NARROW_MS : HOLD_WIDE_MS;
  wire [15:0] nxt_val  = meas_unmeasured ? `UNMEASURED : meas_value;

  // command handling and the sweep stream engine
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff     <= S_IDLE;
      msg_ff       <= 96'h0;
      msg_len_ff   <= 4'h0;
      sweeping_ff  <= 1'b0;
      abort_ff     <= 1'b0;
      reply_ff     <= `RPL_NONE;
      sel_mask_ff  <= 6'h01;
      sel_smart_ff <= 1'b0;
      sw_mask_ff   <= 6'h00;
      sw_smart_ff  <= 1'b0;
      det_idx_ff   <= 3'h0;
      cur_ff       <= 33'h0;
      limit_ff     <= 33'h0;
      step_amt_ff  <= 32'h0;
      point_ff     <= 32'h0;
      val_ff       <= 16'h0000;
      meas_req_ff  <= 1'b0;
      meas_hold_ff <= 32'h0;
      table_ff     <= 1'b0;
      tx_valid_ff  <= 1'b0;
      tx_data_ff   <= 8'h00;
      rbw_out_ff   <= 5'h00;
      att_out_ff   <= 8'h00;
      att_auto_ff  <= 1'b0;
      preamp_on_ff <= 1'b0;
      presel_on_ff <= 1'b0;
      fft_ff       <= 1'b0;
    end else begin
      // abort latches until consumed
      if (cmd_wr && cmd == `CMD_ABORT && sweeping_ff) abort_ff <= 1'b1;
      // commands refused while sweeping
      if (cmd_wr && cmd != `CMD_ABORT && sweeping_ff) reply_ff <= `RPL_REJECT;
      if (cmd_wr && cmd == `CMD_ABORT && !sweeping_ff) reply_ff <= `RPL_REJECT;
      case (state_ff)
        S_IDLE: begin
          if (cmd_wr && cmd == `CMD_DET_SEL) begin
            reply_ff <= det_sel_ok ? `RPL_OK : `RPL_REJECT;
            if (det_sel_ok) begin
              sel_mask_ff  <= dec_mask;
              sel_smart_ff <= dec_smart;
            end
          end else if (cmd_wr && cmd == `CMD_FREE_SWEEP) begin
            state_ff <= S_MSG;
            if (errn != 4'h0) begin
              reply_ff   <= `RPL_ERR_BASE + {1'b0, errn};
              msg_ff     <= {`MSG_ERR_HEAD, 8'h30 + {4'h0, errn}, 16'h0D0A, 8'h00};
              msg_len_ff <= `LEN_ERR;
            end else begin
              reply_ff     <= `RPL_ACCEPT;
              msg_ff       <= `MSG_ACCEPT;
              msg_len_ff   <= `LEN_ACCEPT;
              sweeping_ff  <= 1'b1;
              sw_mask_ff   <= dec_mask;
              sw_smart_ff  <= dec_smart;
              det_idx_ff   <= 3'h0;
              point_ff     <= 32'h0;
              table_ff     <= (step_s == 0);
              cur_ff       <= (step_s == 0) ? 33'h0 : {1'b0, start_ff};
              limit_ff     <= (step_s == 0) ? {26'h0, scan_table_count - 7'h01} : {1'b0, stop_ff};
              step_amt_ff  <= (step_s > 0) ? step_ff : (step_s < 0) ? AUTO_STEP_HZ : 32'h1;
              rbw_out_ff   <= rbw_ff[4:0];
              att_out_ff   <= att_ff[7:0];
              att_auto_ff  <= 1'b1;
              preamp_on_ff <= ((preamp_ff & `CASE_MASK) == `STR_ON);
              presel_on_ff <= ((presel_ff & `CASE_MASK) == `STR_ON);
              fft_ff       <= fft_ok;
            end
          end
        end
        S_MSG: begin
          tx_valid_ff <= 1'b1;
          tx_data_ff  <= msg_ff[95:88];
          if (tx_valid_ff && tx_ready) begin
            msg_ff     <= {msg_ff[87:0], 8'h00};
            tx_data_ff <= msg_ff[87:80];
            msg_len_ff <= msg_len_ff - 4'h1;
            if (msg_len_ff == 4'h1) begin
              tx_valid_ff <= 1'b0;
              state_ff    <= sweeping_ff ? S_FIND : S_IDLE;
            end
          end
        end
        S_FIND: begin
          if (abort_ff) begin
            abort_ff    <= 1'b0;
            sweeping_ff <= 1'b0;
            att_auto_ff <= 1'b0;
            reply_ff    <= `RPL_ABORTED;
            msg_ff      <= `MSG_ABORT;
            msg_len_ff  <= `LEN_ABORT;
            state_ff    <= S_MSG;
          end else if (cur_ff > limit_ff) begin
            sweeping_ff <= 1'b0;
            att_auto_ff <= 1'b0;
            reply_ff    <= `RPL_DONE;
            msg_ff      <= `MSG_DONE;
            msg_len_ff  <= `LEN_DONE;
            state_ff    <= S_MSG;
          end else if (sw_mask_ff[det_idx_ff]) begin
            meas_req_ff  <= 1'b1;
            // smart peak pass: scan hold or minimum
            if (sw_smart_ff && det_idx_ff == 3'h0)
              meas_hold_ff <= scan_hold_ff[31] ? min_hold : scan_hold_ff;
            else
              meas_hold_ff <= hold_ff;
            state_ff <= S_REQ;
          end else if (last_det) begin
            det_idx_ff <= 3'h0;
            cur_ff     <= cur_ff + {1'b0, step_amt_ff};
            point_ff   <= point_ff + 32'h1;
          end else begin
            det_idx_ff <= det_idx_ff + 3'h1;
          end
        end
        S_REQ: begin
          if (abort_ff) begin
            meas_req_ff <= 1'b0;
            state_ff    <= S_FIND;
          end else if (meas_valid) begin
            meas_req_ff <= 1'b0;
            val_ff      <= nxt_val;
            tx_data_ff  <= nxt_val[7:0];
            tx_valid_ff <= 1'b1;
            state_ff    <= S_TXLO;
          end
        end
        S_TXLO: begin
          if (tx_ready) begin
            tx_data_ff <= val_ff[15:8];
            state_ff   <= S_TXHI;
          end
        end
        S_TXHI: begin
          if (tx_ready) begin
            tx_valid_ff <= 1'b0;
            state_ff    <= S_FIND;
            if (last_det) begin
              det_idx_ff <= 3'h0;
              cur_ff     <= cur_ff + {1'b0, step_amt_ff};
              point_ff   <= point_ff + 32'h1;
            end else begin
              det_idx_ff <= det_idx_ff + 3'h1;
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // output drive
  assign s_axi_awready   = awready_ff;
  assign s_axi_wready    = wready_ff;
  assign s_axi_bresp     = bresp_ff;
  assign s_axi_bvalid    = bvalid_ff;
  assign s_axi_arready   = arready_ff;
  assign s_axi_rdata     = rdata_ff;
  assign s_axi_rresp     = rresp_ff;
  assign s_axi_rvalid    = rvalid_ff;
  assign meas_req        = meas_req_ff;
  assign meas_det        = det_idx_ff;
  assign meas_hold_ms    = meas_hold_ff;
  assign tune_freq       = cur_ff[31:0];
  assign tune_from_table = table_ff;
  assign rbw_idx         = rbw_out_ff;
  assign min_att         = att_out_ff;
  assign att_auto        = att_auto_ff;
  assign preamp_on       = preamp_on_ff;
  assign presel_on       = presel_on_ff;
  assign use_fft         = fft_ff;
  assign tx_valid        = tx_valid_ff;
  assign tx_data         = tx_data_ff;
endmodule // sweep_command_interpreter
`default_nettype wire

// ==== verification/sweep_cmd_checker.sv ====
// checker of the result stream and applied sweep settings
// bound into the interpreter, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module sweep_cmd_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // measurement and stream
  input wire logic        meas_req,
  input wire logic        meas_valid,
  input wire logic        meas_unmeasured,
  input wire logic [15:0] meas_value,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_data,
  // settings
  input wire logic        att_auto,
  input wire logic [7:0]  min_att,
  input wire logic [7:0]  max_att,
  input wire logic [4:0]  rbw_idx,
  input wire logic        use_fft
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // stream bytes and their order
  chk_tx_hold:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("byte lost");
  chk_low_first:
    assert property (meas_req && meas_valid && !meas_unmeasured |=> tx_valid && tx_data == 8'($past(meas_value)))
    else $error("low byte");
  chk_high_next:
    assert property (meas_req && meas_valid && !meas_unmeasured ##1 tx_ready |=> tx_data == 8'($past(meas_value, 2) >> 8))
    else $error("high byte");
  chk_marker_low:
    assert property (meas_req && meas_valid && meas_unmeasured |=> tx_valid && tx_data == 8'h44) else $error("marker");
  chk_req_drop:
    assert property (meas_req && meas_valid |=> !meas_req) else $error("request held");
  // settings applied while sweeping
  chk_att_auto:
    assert property (meas_req |-> att_auto && min_att <= max_att && min_att % 8'h05 == 8'h00) else $error("attenuation");
  chk_rbw_legal:
    assert property (meas_req |-> rbw_idx inside {[5'h01:5'h07], [5'h09:5'h0C], [5'h16:5'h18]}) else $error("bandwidth");
  chk_fft_rbw:
    assert property (use_fft |-> rbw_idx == 5'h07) else $error("fft");
endmodule // sweep_cmd_checker
bind sweep_command_interpreter sweep_cmd_checker i_sweep_cmd_checker (.clk_sys, .rst, .meas_req, .meas_valid,
  .meas_unmeasured, .meas_value, .tx_valid, .tx_ready, .tx_data, .att_auto, .min_att, .max_att, .rbw_idx, .use_fft);
`default_nettype wire

// ==== verification/meas_partner.sv ====
// measurement front end and host stream pacing
// same clock as the interpreter
`timescale 1ns/100ps
`default_nettype none
module meas_partner (
  // clock
  input  wire logic        clk_sys,
  // measurement handshake
  input  wire logic        meas_req,
  input  wire logic [2:0]  meas_det,
  output var  logic        meas_valid = 1'h0,
  output wire logic        meas_unmeasured,
  output var  logic [15:0] meas_value = 16'h0,
  // stream pacing
  output var  logic        tx_ready = 1'h0
);
  logic [3:0] cnt_ff = 4'h0;
  // quasi-peak stays unmeasured
  assign meas_unmeasured = meas_det == 3'h1;
  // varying answer delay, stalls, noise when idle
  always @(posedge clk_sys) begin
    cnt_ff <= cnt_ff + 4'h1;
    tx_ready <= cnt_ff[0] | cnt_ff[2];
    meas_valid <= meas_req && !meas_valid && cnt_ff[1];
    meas_value <= meas_req && !meas_valid && cnt_ff[1] ? {5'h15, meas_det, 5'h0A, meas_det} : ~meas_value;
  end
endmodule // meas_partner
`default_nettype wire

// ==== verification/tb_sweep_command_interpreter.sv ====
// testbench: register tasks, errors, full sweep, abort
// partner model answers measurements and paces the stream
`timescale 1ns/100ps
`default_nettype none
`include "sweep_cmd_regs.vh"
module tb_sweep_command_interpreter;
  logic clk_sys = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, r;
  wire awr, wrdy, bv, arr, rv, mrq, mv, mu, txv, txr;
  wire [1:0] br;
  wire [2:0] mdet;
  wire [7:0] txd;
  wire [15:0] mval;
  wire [31:0] rdat;
  int error_cnt = 0, checks_done = 0;
  logic [7:0] q[$];
  logic [31:0] base[1:10] = '{32'h3E8, 32'h3EA, 32'h1, 32'h515052, 32'h0, 32'h0, 32'h6, 32'hA, 32'h66666F, 32'h4E4F};
  logic [5:0] eo[8] = '{6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A};
  logic [31:0] ev[8] = '{32'h7D0, 32'h0, 32'h58, 32'h2711, 32'h2, 32'h7, 32'h786F, 32'h0};
  sweep_command_interpreter i_sweep_command_interpreter (.clk_sys, .rst, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb({4{wv}}), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .limit_active(1'h1), .unit_downconv(1'h0), .mil_avail(1'h1), .max_att(8'h1E), .scan_table_count(7'h01),
    .meas_req(mrq), .meas_det(mdet), .meas_hold_ms(), .tune_freq(), .tune_from_table(), .meas_valid(mv),
    .meas_unmeasured(mu), .meas_value(mval), .rbw_idx(), .min_att(), .att_auto(), .preamp_on(), .presel_on(),
    .use_fft(), .tx_valid(txv), .tx_data(txd), .tx_ready(txr));
  meas_partner i_meas_partner (.clk_sys, .meas_req(mrq), .meas_det(mdet), .meas_valid(mv), .meas_unmeasured(mu),
    .meas_value(mval), .tx_ready(txr));
  // clock and byte collector
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (txv && txr) q.push_back(txd);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    awa <= {a, 2'h0};
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (!bv);
    r = {30'h0, br};
    bry <= 1'h0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [5:0] a);
    ara <= {a, 2'h0};
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'h0;
    end while (!rv);
    r = rdat;
    rry <= 1'h0;
    @(posedge clk_sys);
  endtask
  // wait for a message end, compare a text image
  task drain(input int n);
    while (q.size() < n || q[q.size()-1] !== 8'h0A) @(posedge clk_sys);
  endtask
  task mchk(input int b, input logic [95:0] m, input int n);
    for (int i = 0; i < n; i++) chk(q[b+i], m[95-8*i -: 8]);
  endtask
  task end_sim;
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rd(`OFS_SELECT); chk(r, 32'h1);
    wr(`OFS_DET_LO, 32'h51); wr(`OFS_CMD, `CMD_DET_SEL); rd(`OFS_SELECT); chk(r, 32'h2);
    wr(`OFS_DET_LO, 32'h58); wr(`OFS_CMD, `CMD_DET_SEL); rd(`OFS_STATUS); chk(r[4:0], `RPL_REJECT);
    wr(6'h0F, 32'h1); chk(r, 32'h2);
    rd(6'h0F); chk(r, 32'h0);
    for (int i = 1; i <= 10; i++) wr(i[5:0], base[i]);
    for (int e = 0; e < 8; e++) begin
      wr(eo[e], ev[e]); q.delete(); wr(`OFS_CMD, `CMD_FREE_SWEEP); drain(11);
      rd(`OFS_STATUS); chk(r[5:0], 6'h11 + e[5:0]);
      mchk(0, {`MSG_ERR_HEAD, 32'h0}, 8); chk(q[8], 8'h31 + e[7:0]);
      wr(eo[e], base[eo[e]]);
    end
    q.delete(); wr(`OFS_CMD, `CMD_FREE_SWEEP); drain(35); mchk(0, `MSG_ACCEPT, 8); mchk(26, `MSG_DONE, 9);
    for (int n = 0; n < 9; n++) begin
      chk(q[8+2*n], n % 3 == 1 ? 8'h44 : {5'h0A, 3'(n % 3)});
      chk(q[9+2*n], n % 3 == 1 ? 8'h80 : {5'h15, 3'(n % 3)});
    end
    q.delete(); wr(`OFS_CMD, `CMD_FREE_SWEEP); wait (mrq); wr(`OFS_CMD, `CMD_ABORT); drain(16);
    mchk(q.size() - 8, `MSG_ABORT, 8); rd(`OFS_STATUS); chk(r[4:0], `RPL_ABORTED);
    end_sim;
  end
  // watchdog
  initial begin
    #400000;
    error_cnt++;
    end_sim;
  end
endmodule // tb_sweep_command_interpreter
`default_nettype wire
